// ===== hdl/asp_pkg.sv
package asp_pkg;
  localparam int ASP_ADDR_W = 18;
  localparam logic [17:0] ASP_OFF_CTRL = 18'h00000;
  localparam logic [17:0] ASP_OFF_STATUS = 18'h00004;
  localparam logic [17:0] ASP_OFF_RD_CHAN = 18'h00008;
  localparam logic [17:0] ASP_OFF_RD_START = 18'h0000c;
  localparam logic [17:0] ASP_OFF_RD_LEN = 18'h00010;
  localparam logic [17:0] ASP_OFF_RD_DATA = 18'h00014;
  localparam logic [17:0] ASP_OFF_BYTE_PACK = 18'h3118c;
  localparam int ASP_CTRL_RUN = 0;
  localparam int ASP_CTRL_OVR_EN = 1;
  localparam int ASP_CTRL_STREAM = 2;
  localparam int ASP_CTRL_CH_LSB = 4;
  localparam int ASP_CTRL_RATE_LSB = 8;
  localparam int ASP_ST_REC = 0;
  localparam int ASP_ST_ILV = 1;
  localparam int ASP_ST_FULL = 2;
  localparam int ASP_ST_WP_LSB = 16;
  localparam logic [31:0] ASP_CTRL_RST = 32'h00000000;
  localparam logic [31:0] ASP_PACK_RST = 32'h00000000;
  localparam int ASP_RATE_LOW_MSPS = 160;
  localparam int ASP_RATE_HIGH_MSPS = 200;
  localparam logic [2:0] ASP_RATE_FASTEST = 3'h7;
  localparam int ASP_SYNC_STAGES = 2;
endpackage

// ===== hdl/asp_sync.sv
`timescale 1ns/1ps
module asp_sync import asp_pkg::*; #(
  parameter int W = 52
) (
  input wire logic core_clk_i, // Sample clock.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic ce_i, // Clock enable.
  input wire logic [W-1:0] d_i, // Pin-side input.
  output logic [W-1:0] q_o // Synchronised output.
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // Only the second stage is visible outside this module.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else if (ce_i) begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule // asp_sync

// ===== hdl/asp_word_fmt.sv
`timescale 1ns/1ps
module asp_word_fmt import asp_pkg::*; (
  input wire logic [11:0] first_i, // First converter result of a module.
  input wire logic [11:0] second_i, // Second converter result of a module.
  input wire logic first_ovr_i, // Overrange of first converter.
  input wire logic second_ovr_i, // Overrange of second converter.
  input wire logic ovr_en_i, // Overrange reporting enable.
  output logic [15:0] first_word_o, // Normal word of first converter.
  output logic [15:0] second_word_o, // Normal word of second converter.
  output logic [15:0] packed_o // Byte-packed word of the pair.
);
  wire first_top = ovr_en_i ? first_ovr_i : first_i[11];
  wire second_top = ovr_en_i ? second_ovr_i : second_i[11];

  assign first_word_o = {first_top, {3{first_i[11]}}, first_i};
  assign second_word_o = {second_top, {3{second_i[11]}}, second_i};
  // Bits 3..0 are dropped, so packed data can not carry overrange.
  assign packed_o = {second_i[11:4], first_i[11:4]};
endmodule // asp_word_fmt

// ===== hdl/asp_top.sv
`timescale 1ns/1ps
module asp_top import asp_pkg::*; #(
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic core_clk_i, // Sample clock, 100 MHz.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic ce_i, // Clock enable; low freezes all state.
  input wire logic [11:0] module1_first_converter_i, // Converter 0 pins.
  input wire logic [11:0] module1_second_converter_i, // Converter 1 pins.
  input wire logic [11:0] module2_first_converter_i, // Converter 2 pins.
  input wire logic [11:0] module2_second_converter_i, // Converter 3 pins.
  input wire logic [3:0] overrange_i, // Overrange pins, one per converter.
  input wire logic psel_i, // APB select.
  input wire logic penable_i, // APB enable.
  input wire logic pwrite_i, // APB write.
  input wire logic [ASP_ADDR_W-1:0] paddr_i, // APB byte address.
  input wire logic [31:0] pwdata_i, // APB write data.
  output logic [31:0] prdata_o, // APB read data.
  output logic pready_o, // APB ready.
  output logic pslverr_o, // APB error for unmapped address.
  output logic recording_o, // Recording in progress.
  output logic interlace_o // Interlace mode active.
);
  // Synchronised pin word; converter n sits at bits 12n+11 down to 12n.
  logic [51:0] pins_sync;
  logic [11:0] c0;
  logic [11:0] c1;
  logic [11:0] c2;
  logic [11:0] c3;
  logic [3:0] ovr;
  // Formatted words per converter and packed words per module.
  logic [15:0] w0;
  logic [15:0] w1;
  logic [15:0] w2;
  logic [15:0] w3;
  logic [15:0] pk1;
  logic [15:0] pk2;

  logic [31:0] ctrl_q;
  logic [31:0] pack_q;
  logic rd_chan_q;
  logic [AW:0] rp_q;
  logic [31:0] rem_q;
  // Write pointers are one bit wider so that a full memory reads DEPTH.
  logic [AW:0] wp0_q;
  logic [AW:0] wp1_q;
  logic rec_q;
  logic full_q;
  logic ilv_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [15:0] mem0 [DEPTH];
  logic [15:0] mem1 [DEPTH];

  // All pins, overrange included, pass the same two stages so that a
  // sample and its overrange flag stay aligned.
  asp_sync #(.W(52)) u_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i({overrange_i, module2_second_converter_i,
          module2_first_converter_i, module1_second_converter_i,
          module1_first_converter_i}),
    .q_o(pins_sync)
  );

  assign c0 = pins_sync[11:0];
  assign c1 = pins_sync[23:12];
  assign c2 = pins_sync[35:24];
  assign c3 = pins_sync[47:36];
  assign ovr = pins_sync[51:48];

  // Module 1 holds converters 0 and 1, module 2 converters 2 and 3.
  asp_word_fmt u_fmt1 (
    .first_i(c0),
    .second_i(c1),
    .first_ovr_i(ovr[0]),
    .second_ovr_i(ovr[1]),
    .ovr_en_i(ctrl_q[ASP_CTRL_OVR_EN]),
    .first_word_o(w0),
    .second_word_o(w1),
    .packed_o(pk1)
  );

  asp_word_fmt u_fmt2 (
    .first_i(c2),
    .second_i(c3),
    .first_ovr_i(ovr[2]),
    .second_ovr_i(ovr[3]),
    .ovr_en_i(ctrl_q[ASP_CTRL_OVR_EN]),
    .first_word_o(w2),
    .second_word_o(w3),
    .packed_o(pk2)
  );

  // Mode selection. Mode changes take effect on the next clock; software
  // should stop recording before it changes the channel set or format,
  // since words already stored are not converted.
  wire [3:0] ch_en = ctrl_q[ASP_CTRL_CH_LSB +: 4];
  wire [2:0] rate_sel = ctrl_q[ASP_CTRL_RATE_LSB +: 3];
  wire pack_on = pack_q[0];
  // Interlace yields to packing; both at once would need two pair words.
  wire ilv_on = (ch_en == 4'h1) && (rate_sel == ASP_RATE_FASTEST) &&
                !ctrl_q[ASP_CTRL_STREAM] && !pack_on;

  // Per memory channel: up to two words each clock, a goes first.
  logic [15:0] m0_a;
  logic [15:0] m0_b;
  logic [15:0] m1_a;
  logic [15:0] m1_b;
  // Word count per memory channel this clock: 0, 1 or 2.
  logic [1:0] m0_n;
  logic [1:0] m1_n;

  // Normal mode: each module fills its own memory channel with its
  // enabled converters in ascending order.
  wire [1:0] n_mod1 = {1'b0, ch_en[0]} + {1'b0, ch_en[1]};
  wire [1:0] n_mod2 = {1'b0, ch_en[2]} + {1'b0, ch_en[3]};
  // Packing: one word per module whose first converter is enabled.
  wire [1:0] n_pack = {1'b0, ch_en[0]} + {1'b0, ch_en[2]};

  always_comb begin
    if (ilv_on) begin
      // Converter 1 takes the odd samples and converter 0 the even ones.
      m0_a = w1;
      m0_b = w1;
      m0_n = 2'h1;
      m1_a = w0;
      m1_b = w0;
      m1_n = 2'h1;
    end else if (pack_on) begin
      // One word per pair instead of two keeps bandwidth at half.
      m0_a = ch_en[0] ? pk1 : pk2;
      m0_b = pk2;
      m0_n = n_pack;
      // Memory channel 1 stays idle while packing.
      m1_a = pk2;
      m1_b = pk2;
      m1_n = 2'h0;
    end else begin
      m0_a = ch_en[0] ? w0 : w1;
      m0_b = w1;
      m0_n = n_mod1;
      m1_a = ch_en[2] ? w2 : w3;
      m1_b = w3;
      m1_n = n_mod2;
    end
  end

  // The sums are checked against DEPTH before any word is written, so a
  // clock never stores only part of its words.
  wire [AW+1:0] wp0_nx = {1'b0, wp0_q} + {{AW{1'b0}}, m0_n};
  wire [AW+1:0] wp1_nx = {1'b0, wp1_q} + {{AW{1'b0}}, m1_n};
  localparam logic [AW+1:0] DEPTH_W = (AW+2)'(DEPTH);
  wire room = (wp0_nx <= DEPTH_W) && (wp1_nx <= DEPTH_W);
  wire wr_go = rec_q && room;
  wire [AW-1:0] wp0_b = wp0_q[AW-1:0] + {{(AW-1){1'b0}}, 1'b1};
  wire [AW-1:0] wp1_b = wp1_q[AW-1:0] + {{(AW-1){1'b0}}, 1'b1};

  // APB decode. Addresses are compared whole, so an offset with stray
  // low bits is refused rather than aliased onto a register.
  wire acc = psel_i && penable_i;
  wire done = acc && pready_q;
  wire hit_ctrl = (paddr_i == ASP_OFF_CTRL);
  wire hit_status = (paddr_i == ASP_OFF_STATUS);
  wire hit_chan = (paddr_i == ASP_OFF_RD_CHAN);
  wire hit_start = (paddr_i == ASP_OFF_RD_START);
  wire hit_len = (paddr_i == ASP_OFF_RD_LEN);
  wire hit_data = (paddr_i == ASP_OFF_RD_DATA);
  wire hit_pack = (paddr_i == ASP_OFF_BYTE_PACK);
  wire mapped = hit_ctrl || hit_status || hit_chan || hit_start ||
                hit_len || hit_data || hit_pack;
  wire wr_done = done && pwrite_i && mapped;
  wire rd_data_done = done && !pwrite_i && hit_data && (rem_q != 32'h0);
  // A run starts only on a completed, mapped write to control.
  wire run_set = wr_done && hit_ctrl && pwdata_i[ASP_CTRL_RUN];

  // The readout pointer indexes words, so a packed word counts as one
  // sample position whatever it carries.
  wire [15:0] mem_word = rd_chan_q ? mem1[rp_q[AW-1:0]] : mem0[rp_q[AW-1:0]];
  // Status carries the write pointer of memory 0 in its upper half.
  wire [31:0] status_word = {{(16-AW-1){1'b0}}, wp0_q, 13'h0, full_q,
                             ilv_q, rec_q};
  // Register read mux; an unmapped address reads as zero.
  wire [31:0] rd_mux;
  assign rd_mux = hit_ctrl ? ctrl_q :
                  hit_status ? status_word :
                  hit_chan ? {31'h0, rd_chan_q} :
                  hit_start ? {{(31-AW){1'b0}}, rp_q} :
                  hit_len ? rem_q :
                  (hit_data && rem_q != 32'h0) ? {16'h0, mem_word} :
                  hit_pack ? {31'h0, pack_q[0]} : 32'h0;

  // One wait state: data is registered, then taken on the pready edge.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
    end else if (ce_i) begin
      // Ready alternates, so back-to-back accesses each get one wait.
      pready_q <= acc && !pready_q;
      if (acc && !pready_q) begin
        prdata_q <= pwrite_i ? 32'h0 : rd_mux;
        pslverr_q <= !mapped;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctrl_q <= ASP_CTRL_RST;
      pack_q <= ASP_PACK_RST;
      rd_chan_q <= 1'b0;
    end else if (ce_i && wr_done) begin
      if (hit_ctrl) begin
        // The run bit is a strobe: it is never stored and reads back 0.
        ctrl_q <= {pwdata_i[31:1], 1'b0};
      end else if (hit_pack) begin
        pack_q <= {31'h0, pwdata_i[0]};
      end else if (hit_chan) begin
        rd_chan_q <= pwdata_i[0];
      end
    end
  end

  // Readout pointer in samples, independent of bytes per sample.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rp_q <= '0;
      rem_q <= 32'h0;
    end else if (ce_i) begin
      if (wr_done && hit_start) begin
        rp_q <= pwdata_i[AW:0];
      end else if (rd_data_done) begin
        rp_q <= rp_q + {{AW{1'b0}}, 1'b1};
      end
      // The length counts down; reads past it return 0 and move nothing.
      if (wr_done && hit_len) begin
        rem_q <= pwdata_i;
      end else if (rd_data_done) begin
        rem_q <= rem_q - 32'h1;
      end
    end
  end

  // Recording stops at the first clock that would overflow either memory.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rec_q <= 1'b0;
      full_q <= 1'b0;
      ilv_q <= 1'b0;
      wp0_q <= '0;
      wp1_q <= '0;
    end else if (ce_i) begin
      // Reported from the settings alone, so software can check the
      // mode before starting a run.
      ilv_q <= ilv_on;
      // A new run restarts both pointers and drops the full flag.
      if (run_set) begin
        rec_q <= 1'b1;
        full_q <= 1'b0;
        wp0_q <= '0;
        wp1_q <= '0;
      end else if (wr_go) begin
        wp0_q <= wp0_nx[AW:0];
        wp1_q <= wp1_nx[AW:0];
      end else if (rec_q) begin
        rec_q <= 1'b0;
        full_q <= 1'b1;
      end
    end
  end

  // The memories have no reset; only words below the write pointer are
  // meaningful after a run.
  always_ff @(posedge core_clk_i) begin
    if (ce_i && wr_go) begin
      if (m0_n != 2'h0) begin
        mem0[wp0_q[AW-1:0]] <= m0_a;
      end
      if (m0_n == 2'h2) begin
        mem0[wp0_b] <= m0_b;
      end
      if (m1_n != 2'h0) begin
        mem1[wp1_q[AW-1:0]] <= m1_a;
      end
      if (m1_n == 2'h2) begin
        mem1[wp1_b] <= m1_b;
      end
    end
  end

  // Every output comes straight from a flop of this module.
  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign recording_o = rec_q;
  assign interlace_o = ilv_q;
endmodule // asp_top

// ===== verif/asp_top_chk.sv
`timescale 1ns/1ps
module asp_top_chk import asp_pkg::*; (
  input wire logic core_clk_i, // Clock.
  input wire logic rst_i, // Reset.
  input wire logic psel_i, // Select.
  input wire logic penable_i, // Enable.
  input wire logic pwrite_i, // Write.
  input wire logic [ASP_ADDR_W-1:0] paddr_i, // Address.
  input wire logic [31:0] pwdata_i, // Write data.
  input wire logic [31:0] prdata_o, // Read data.
  input wire logic pready_o, // Ready.
  input wire logic pslverr_o, // Error.
  input wire logic recording_o, // Recording.
  input wire logic interlace_o // Interlace.
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic [31:0] ctrl_q;
  logic pack_q;
  wire wr_ok = pready_o && pwrite_i && !pslverr_o;
  wire rd_go = pready_o && !pwrite_i;
  wire map_ok = paddr_i inside {ASP_OFF_CTRL, ASP_OFF_STATUS, ASP_OFF_RD_CHAN,
    ASP_OFF_RD_START, ASP_OFF_RD_LEN, ASP_OFF_RD_DATA, ASP_OFF_BYTE_PACK};
  wire ilv_ok = ctrl_q[7:4] == 4'h1 && ctrl_q[10:8] == ASP_RATE_FASTEST &&
    !ctrl_q[ASP_CTRL_STREAM] && !pack_q;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctrl_q <= 32'h0;
      pack_q <= 1'b0;
    end else if (wr_ok && paddr_i == ASP_OFF_CTRL) begin
      ctrl_q <= pwdata_i;
    end else if (wr_ok && paddr_i == ASP_OFF_BYTE_PACK) begin
      pack_q <= pwdata_i[0];
    end
  end
  sequence s_acc_start;
    psel_i && penable_i && !$past(penable_i);
  endsequence
  chk_ready_slot: assert property (s_acc_start |-> !pready_o ##1 pready_o)
    else $error("ready not in second access cycle");
  chk_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  chk_err_addr: assert property (pready_o |-> pslverr_o == !map_ok)
    else $error("error flag does not match address map");
  chk_err_rdata: assert property (rd_go && pslverr_o |-> prdata_o == 32'h0)
    else $error("refused read returned data");
  chk_pack_rdbk: assert property (
    rd_go && paddr_i == ASP_OFF_BYTE_PACK |-> prdata_o[0] == pack_q)
    else $error("packing enable readback wrong");
  chk_ctrl_rdbk: assert property (rd_go && paddr_i == ASP_OFF_CTRL
    |-> prdata_o[10:0] == {ctrl_q[10:1], 1'b0})
    else $error("control readback wrong");
  chk_ilv_cause: assert property (interlace_o |-> ilv_ok || $past(ilv_ok))
    else $error("interlace without its conditions");
  chk_ilv_set: assert property ($rose(ilv_ok) |-> ##[0:3] interlace_o)
    else $error("interlace not entered");
  chk_rec_start: assert property (wr_ok && paddr_i == ASP_OFF_CTRL &&
    pwdata_i[ASP_CTRL_RUN] |-> ##[1:4] recording_o)
    else $error("recording did not start");
endmodule // asp_top_chk
bind asp_top asp_top_chk i_chk (.core_clk_i, .rst_i, .psel_i, .penable_i,
  .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
  .recording_o, .interlace_o);

// ===== verif/asp_conv_model.sv
`timescale 1ns/1ps
module asp_conv_model #(
  parameter logic [11:0] V0 = 12'h5a5,
  parameter logic [11:0] V1 = 12'h9ab,
  parameter logic [11:0] V2 = 12'h7e1,
  parameter logic [11:0] V3 = 12'hc3d
) (
  input wire logic core_clk_i, // Sample clock.
  input wire logic ovr0_i, // Overrange request for converter 0.
  output logic [11:0] conv0_o, // Converter 0 result.
  output logic [11:0] conv1_o, // Converter 1 result.
  output logic [11:0] conv2_o, // Converter 2 result.
  output logic [11:0] conv3_o, // Converter 3 result.
  output logic [3:0] overrange_o // Overrange flags.
);
  // Steady results keep every stored word predictable, at the cost of
  // not seeing a sample slip by one clock.
  always_ff @(posedge core_clk_i) begin
    conv0_o <= V0;
    conv1_o <= V1;
    conv2_o <= V2;
    conv3_o <= V3;
    overrange_o <= {3'h0, ovr0_i};
  end
endmodule // asp_conv_model

// ===== verif/adc_sample_packing_bench.sv
`timescale 1ns/1ps
module adc_sample_packing_bench import asp_pkg::*; ;
  logic clk, rst, psel, pen, pwr, pready, perr, rec_o, ilv, ovr0, err;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] c0, c1, c2, c3;
  logic [3:0] ovr;
  logic [31:0] cfg [4] = '{32'h610, 32'h714, 32'h730, 32'h710};
  int failures, samples_checked, i;
  asp_conv_model
    i_conv (.core_clk_i(clk), .ovr0_i(ovr0), .conv0_o(c0), .conv1_o(c1),
    .conv2_o(c2), .conv3_o(c3), .overrange_o(ovr));
  asp_top #(.DEPTH(16), .AW(4)) i_dut (.core_clk_i(clk), .rst_i(rst),
    .ce_i(1'b1), .module1_first_converter_i(c0),
    .module1_second_converter_i(c1), .module2_first_converter_i(c2),
    .module2_second_converter_i(c3), .overrange_i(ovr), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr),
    .recording_o(rec_o), .interlace_o(ilv));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task close_out;
    $display("Checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n == 20) begin
      failures++;
      close_out();
    end
  endtask
  task rd_chk(input logic [17:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp(rd, e);
  endtask
  task wait_rec(input logic lvl, input int lim);
    int n;
    for (n = 0; n < lim && rec_o !== lvl; n++) @(posedge clk);
    if (rec_o !== lvl) begin
      failures++;
      close_out();
    end
  endtask
  // Reprogramming first lets the new format settle before the run starts.
  task rec(input logic [31:0] c, input logic ilv_e);
    apb(1'b1, ASP_OFF_CTRL, c);
    apb(1'b1, ASP_OFF_CTRL, c | 32'h1);
    wait_rec(1'b1, 50);
    wait_rec(1'b0, 100);
    apb(1'b0, ASP_OFF_STATUS, 32'h0);
    cmp({29'h0, rd[2:0]}, {29'h0, 1'b1, ilv_e, 1'b0});
  endtask
  task mem_chk(input logic ch, input logic [31:0] st, input logic [31:0] len,
      input logic [15:0] e0, input logic [15:0] e1);
    int k;
    apb(1'b1, ASP_OFF_RD_CHAN, {31'h0, ch});
    apb(1'b1, ASP_OFF_RD_START, st);
    apb(1'b1, ASP_OFF_RD_LEN, len);
    for (k = 0; k < len; k++) begin
      apb(1'b0, ASP_OFF_RD_DATA, 32'h0);
      cmp({16'h0, rd[15:0]}, {16'h0, ((st + k) % 2) ? e1 : e0});
    end
    rd_chk(ASP_OFF_RD_DATA, 32'h0);
    rd_chk(ASP_OFF_RD_START, st + len);
  endtask
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 18'h0;
    pwdata = 32'h0;
    ovr0 = 1'b0;
    failures = 0;
    samples_checked = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd_chk(ASP_OFF_CTRL, ASP_CTRL_RST);
    rd_chk(ASP_OFF_BYTE_PACK, ASP_PACK_RST);
    apb(1'b1, ASP_OFF_BYTE_PACK, 32'h1);
    rd_chk(ASP_OFF_BYTE_PACK, 32'h1);
    rd_chk(18'h00018, 32'h0);
    cmp({31'h0, err}, 32'h1);
    apb(1'b1, ASP_OFF_BYTE_PACK, 32'h0);
    ovr0 <= 1'b1;
    rec(32'h12, 1'b0);
    mem_chk(1'b0, 32'h3, 32'h4, 16'h85a5, 16'h85a5);
    rec(32'hf0, 1'b0);
    mem_chk(1'b0, 32'h0, 32'h10, 16'h05a5, 16'hf9ab);
    mem_chk(1'b1, 32'h0, 32'h10, 16'h07e1, 16'hfc3d);
    apb(1'b1, ASP_OFF_BYTE_PACK, 32'h1);
    rec(32'h52, 1'b0);
    mem_chk(1'b0, 32'h0, 32'h10, 16'h9a5a, 16'hc37e);
    apb(1'b1, ASP_OFF_BYTE_PACK, 32'h0);
    rec(32'h710, 1'b1);
    mem_chk(1'b1, 32'h0, 32'h8, 16'h05a5, 16'h05a5);
    mem_chk(1'b0, 32'h0, 32'h8, 16'hf9ab, 16'hf9ab);
    for (i = 0; i < 4; i++) begin
      apb(1'b1, ASP_OFF_BYTE_PACK, {31'h0, i == 3});
      apb(1'b1, ASP_OFF_CTRL, cfg[i]);
      apb(1'b0, ASP_OFF_STATUS, 32'h0);
      cmp({31'h0, rd[ASP_ST_ILV]}, 32'h0);
    end
    close_out();
  end
endmodule // adc_sample_packing_bench
